// ===== ispc_defs.svh
/*
 * constants for the programming-clamp and security block: link frame layout,
 * opcodes, clamp modes, register offsets, the hold control bit, synchroniser lanes, data values and timing figures.
 * assumes: included by bare name from the pin bank, the top module and the testbench.
 */
`ifndef ISPC_DEFS_SVH
`define ISPC_DEFS_SVH

// link frame: opcode, address, data, shifted msb first
`define ISPC_FRAME_W      20
`define ISPC_OP_MSB       19
`define ISPC_OP_LSB       16
`define ISPC_ADR_MSB      15
`define ISPC_ADR_LSB      8
`define ISPC_DAT_MSB      7
`define ISPC_BCNT_W       5

// opcodes
`define ISPC_OP_ENTER     4'h1
`define ISPC_OP_EXIT      4'h2
`define ISPC_OP_CLAMP     4'h3
`define ISPC_OP_BGMODE    4'h4
`define ISPC_OP_PROG_CFG  4'h5
`define ISPC_OP_READ_CFG  4'h6
`define ISPC_OP_PROG_UFL  4'h7
`define ISPC_OP_READ_UFL  4'h8
`define ISPC_OP_ERASE     4'h9
`define ISPC_OP_SET_SEC   4'hA
`define ISPC_OP_SET_DONE  4'hB
`define ISPC_OP_RELOAD    4'hC

// per-pin clamp modes
`define ISPC_MODE_W       3
`define ISPC_MODE_DEFAULT 3'h0
`define ISPC_MODE_SAMPLE  3'h1
`define ISPC_MODE_HIGH    3'h2
`define ISPC_MODE_LOW     3'h3
`define ISPC_MODE_HIZ     3'h4

// register offsets (byte addresses)
`define ISPC_REG_CTRL     8'h00
`define ISPC_REG_STAT     8'h04
`define ISPC_REG_UADDR    8'h08
`define ISPC_REG_UDATA    8'h0C
`define ISPC_CTRL_HOLD    0

// synchroniser lanes
`define ISPC_SY_TCK       0
`define ISPC_SY_TMS       1
`define ISPC_SY_TDI       2
`define ISPC_SY_CORE      3
`define ISPC_SY_IO        4
`define ISPC_SY_W         5

// data values
`define ISPC_SECURE_PAT   8'h00
`define ISPC_ERASED       8'hFF

// configuration load time and clock
`define ISPC_T_CONFIG_US  450
`define ISPC_CLK_PERIOD_NS 10
`define ISPC_NS_PER_US    1000

`endif

// ===== ispc_pkg.sv
/*
 * types shared by the programming-clamp and security block.
 * assumes: nothing beyond the constants header.
 */
package ispc_pkg;
	// configuration sequencer states
	typedef enum logic [2:0] {ST_OFF, ST_LOAD, ST_CLEAR, ST_RUN, ST_USER, ST_PROG} ispc_state_e;
	// one clamp mode field
	typedef logic [2:0] ispc_mode_t;
endpackage : ispc_pkg

// ===== ispc_pad_if.sv
/*
 * carrier between the sequencer and the pin bank.
 * assumes: both ends on the same clock; mode holds one field per pin.
 */
`timescale 1ns/1ps
interface ispc_pad_if #(parameter int N = 8);
	logic           gate_off;   // pins may not drive in user mode
	logic           prog;       // programming sequence active
	logic           clamp_en;   // clamp fields apply
	logic           sample_stb; // capture user levels now
	logic [3*N-1:0] mode;       // clamp mode per pin
	logic [N-1:0]   user_out;   // core output levels
	logic [N-1:0]   user_oe;    // core output enables
	logic [N-1:0]   pad_out;    // pad drive level
	logic [N-1:0]   pad_oe;     // pad output enable
	logic [N-1:0]   pad_pu;     // weak pull-up enable
	modport ctl  (output gate_off, prog, clamp_en, sample_stb, mode, user_out, user_oe,
		input pad_out, pad_oe, pad_pu);
	modport bank (input gate_off, prog, clamp_en, sample_stb, mode, user_out, user_oe,
		output pad_out, pad_oe, pad_pu);
endinterface : ispc_pad_if

// ===== ispc_pinbank.sv
/*
 * pin bank: per-pin output, enable and pull-up flops with clamp handling.
 * assumes: control inputs come from flops of the sequencer on the same clock.
 */
`timescale 1ns/1ps
`include "ispc_defs.svh"
module ispc_pinbank #(
	parameter int N = 8
) (
	input wire logic clock,
	input wire logic rstn,
	ispc_pad_if.bank pif
);
	genvar i;
	generate
		for (i = 0; i < N; i++)
		begin : g_pin
			logic held_out_r, held_out_nxt; // sampled level
			logic held_oe_r,  held_oe_nxt;  // sampled direction
			logic out_r,      out_nxt;      // pad level
			logic oe_r,       oe_nxt;       // pad enable
			logic pu_r,       pu_nxt;       // pull-up
			ispc_pkg::ispc_mode_t md;      // this pin's clamp field
			assign md = pif.mode[i*`ISPC_MODE_W +: `ISPC_MODE_W];

			// next pad state by priority: clamp in programming, gate, user
			always_comb
			begin
				held_out_nxt = held_out_r;
				held_oe_nxt  = held_oe_r;
				out_nxt      = 1'b0;
				oe_nxt       = 1'b0;
				pu_nxt       = 1'b1;
				// capture the running level at entry
				if (pif.sample_stb)
				begin
					held_out_nxt = pif.user_out[i];
					held_oe_nxt  = pif.user_oe[i];
				end
				if (pif.prog)
				begin
					if (pif.clamp_en)
					begin
						case (md)
							`ISPC_MODE_SAMPLE:
							begin
								// inputs stay tri-stated [RULE2]
								oe_nxt  = held_oe_r;
								out_nxt = held_out_r;
								pu_nxt  = ~held_oe_r;
							end
							`ISPC_MODE_HIGH:
							begin
								oe_nxt = 1'b1; // forced high [RULE3]
								out_nxt = 1'b1;
								pu_nxt = 1'b0;
							end
							`ISPC_MODE_LOW:
							begin
								oe_nxt = 1'b1; // forced low [RULE3]
								pu_nxt = 1'b0;
							end
							`ISPC_MODE_HIZ:
								pu_nxt = 1'b0; // plain tri-state [RULE3]
							default:
								pu_nxt = 1'b1; // default hold [RULE1]
						endcase
					end
				end
				else if (!pif.gate_off)
				begin
					// user mode: core drives the pin
					oe_nxt  = pif.user_oe[i];
					out_nxt = pif.user_out[i];
					pu_nxt  = 1'b0;
				end
			end

			// register the pad state
			always_ff @(posedge clock)
			begin
				if (!rstn)
				begin
					held_out_r <= 1'b0;
					held_oe_r  <= 1'b0;
					out_r      <= 1'b0;
					oe_r       <= 1'b0;
					pu_r       <= 1'b1;
				end
				else
				begin
					held_out_r <= held_out_nxt;
					held_oe_r  <= held_oe_nxt;
					out_r      <= out_nxt;
					oe_r       <= oe_nxt;
					pu_r       <= pu_nxt;
				end
			end
			assign pif.pad_out[i] = out_r;
			assign pif.pad_oe[i]  = oe_r;
			assign pif.pad_pu[i]  = pu_r;
		end
	endgenerate

	// forced-high clamp on pin 0 shows one cycle later
	clamp_high_a: assert property (@(posedge clock) disable iff (!rstn) // [RULE3]
		pif.prog && pif.clamp_en && pif.mode[`ISPC_MODE_W-1:0] == `ISPC_MODE_HIGH
		|=> pif.pad_oe[0] && pif.pad_out[0])
		else $error("forced high clamp not driven");
endmodule : ispc_pinbank

// ===== ispc_top.sv
/*
 * programming-clamp and security block: link frame decoder, configuration
 * sequencer, configuration and user flash arrays, security and completion
 * bits, supply cutoff, and a small register port for the core.
 * assumes: link pins and supply-good levels are asynchronous; the link clock
 * is much slower than clock; rstn initialises the whole model, flash included.
 */
// Our own choices: the plain strobed port and the placing of the registers.
// Functional notes
// RULE1: programming entry tri-states pins with pull-ups
// RULE2: sample clamp holds outputs, inputs stay hi-z
// RULE3: clamp forces pin high, low or hi-z
// RULE4: background writes while logic keeps running
// RULE5: new image loads only on power cycle (the code also loads on exit and reload frames)
// RULE6: reload command reconfigures without power cycle
// RULE7: reload load time keeps pins hi-z, pulled up
// RULE8: security bit blocks config flash readback
// RULE9: only erase clears the security bit
// RULE10: no readout path for logic cells
// RULE11: user flash readable regardless of security
// RULE12: outputs off until power good and configured
// RULE13: supply low cutoff forces outputs off
// RULE14: pins hi-z until flash load finished
// RULE15: pull-ups enabled during configuration download
// RULE16: completion bit gates all pin driving (clamp drive in programming is not gated by it)
// RULE17: clear logic before releasing pin tri-states
// RULE18: secured reads shift out fixed pattern
`timescale 1ns/1ps
`include "ispc_defs.svh"
module ispc_top #(
	parameter int N        = 8,    // user pins
	parameter int AW       = 8,    // flash address width
	parameter int LOAD_CYC = `ISPC_T_CONFIG_US * `ISPC_NS_PER_US / `ISPC_CLK_PERIOD_NS
) (
	input  wire logic         clock,
	input  wire logic         rstn,
	input  wire logic         tck,
	input  wire logic         tms,
	input  wire logic         tdi,
	output logic              tdo,
	input  wire logic         core_supply_ok,
	input  wire logic         io_supply_ok,
	input  wire logic [N-1:0] user_out,
	input  wire logic [N-1:0] user_oe,
	output logic      [N-1:0] pad_out,
	output logic      [N-1:0] pad_oe,
	output logic      [N-1:0] pad_pu,
	output logic              user_rstn,
	output logic      [7:0]   logic_cfg,
	output logic              supply_low_cutoff,
	input  wire logic [7:0]   reg_addr,
	input  wire logic [31:0]  reg_wdata,
	input  wire logic         reg_wr,
	input  wire logic         reg_rd,
	output logic      [31:0]  reg_rdata
);
	localparam int CW = $clog2(LOAD_CYC + 1);
	localparam int FW = `ISPC_FRAME_W;

	// synchronisers and glitch filter
	logic [`ISPC_SY_W-1:0] s1_r, s2_r, s3_r, filt_r, filt_nxt;
	// link shifters
	logic [FW-1:0]          in_sh_r, in_sh_nxt;      // incoming frame
	logic [`ISPC_BCNT_W-1:0] bcnt_r, bcnt_nxt;       // bits in frame
	logic [7:0]             out_sh_r, out_sh_nxt;    // read answer
	logic                   tdo_nxt;
	// sequencer and flags
	ispc_pkg::ispc_state_e  state_r, state_nxt;      // configuration state
	logic [CW-1:0]          cnt_r, cnt_nxt;          // load timer
	logic                   sec_r, sec_nxt;          // security bit
	logic                   done_r, done_nxt;        // program_complete_bit
	logic                   bg_r, bg_nxt;            // background update mode
	logic                   clamp_r, clamp_nxt;      // clamp fields armed
	logic [3*N-1:0]         mode_r, mode_nxt;        // clamp fields
	logic                   cut_nxt, urst_nxt;
	logic [7:0]             cfg_nxt;
	// register port
	logic                   hold_r, hold_nxt;        // keep core-driven pins off
	logic [AW-1:0]          uaddr_r, uaddr_nxt;      // user_flash index
	logic [31:0]            rdata_nxt;
	// frame decode and flash strobes
	logic                   tck_rise, sel_fall, exec, wr_ok, pwr_ok;
	logic [3:0]             op;
	logic [AW-1:0]          fa;
	logic [7:0]             fd;
	logic                   cfg_we, ufl_we, erase;
	// flash arrays
	logic [7:0]             config_flash [2**AW];
	logic [7:0]             user_flash   [2**AW];

	ispc_pad_if #(.N(N)) pif ();

	// filtered level changes only when second and third stage agree
	assign filt_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & filt_r);
	assign tck_rise = filt_nxt[`ISPC_SY_TCK] & ~filt_r[`ISPC_SY_TCK];
	assign sel_fall = filt_r[`ISPC_SY_TMS] & ~filt_nxt[`ISPC_SY_TMS];
	assign exec     = sel_fall && bcnt_r == `ISPC_BCNT_W'(FW);
	assign op       = in_sh_r[`ISPC_OP_MSB:`ISPC_OP_LSB];
	assign fa       = in_sh_r[`ISPC_ADR_MSB:`ISPC_ADR_LSB];
	assign fd       = in_sh_r[`ISPC_DAT_MSB:0];
	assign pwr_ok   = filt_r[`ISPC_SY_CORE] & filt_r[`ISPC_SY_IO];
	assign wr_ok    = state_r == ispc_pkg::ST_PROG || (state_r == ispc_pkg::ST_USER && bg_r);

	// link: shift frame in on tck rise while tms is high, answer out on tdo
	always_comb
	begin
		in_sh_nxt  = in_sh_r;
		bcnt_nxt   = bcnt_r;
		out_sh_nxt = out_sh_r;
		tdo_nxt    = tdo;
		if (filt_r[`ISPC_SY_TMS] && tck_rise)
		begin
			in_sh_nxt  = {in_sh_r[FW-2:0], filt_nxt[`ISPC_SY_TDI]};
			bcnt_nxt   = (bcnt_r == '1) ? bcnt_r : bcnt_r + 1'b1;
			tdo_nxt    = out_sh_r[7];
			out_sh_nxt = {out_sh_r[6:0], 1'b0};
		end
		if (sel_fall)
			bcnt_nxt = '0; // short or long frames are dropped
		if (exec && wr_ok && op == `ISPC_OP_READ_CFG)
			out_sh_nxt = sec_r ? `ISPC_SECURE_PAT : config_flash[fa]; // [RULE8] [RULE18]
		else if (exec && wr_ok && op == `ISPC_OP_READ_UFL)
			out_sh_nxt = user_flash[fa]; // not subject to security [RULE11]
	end

	// flash strobes; logic cells have no read path at all [RULE10]
	assign cfg_we = exec && wr_ok && op == `ISPC_OP_PROG_CFG; // [RULE4]
	assign ufl_we = exec && wr_ok && op == `ISPC_OP_PROG_UFL;
	assign erase  = exec && wr_ok && op == `ISPC_OP_ERASE;

	// configuration sequencer and protection flags
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		sec_nxt   = sec_r;
		done_nxt  = done_r;
		bg_nxt    = bg_r;
		clamp_nxt = clamp_r;
		mode_nxt  = mode_r;
		cfg_nxt   = logic_cfg;
		pif.sample_stb = 1'b0;
		case (state_r)
			ispc_pkg::ST_OFF:
				if (pwr_ok)
				begin
					state_nxt = ispc_pkg::ST_LOAD; // power cycle loads flash [RULE5]
					cnt_nxt = '0;
				end
			ispc_pkg::ST_LOAD:
			begin
				cnt_nxt = cnt_r + 1'b1;
				if (cnt_r == CW'(LOAD_CYC - 1))
				begin
					state_nxt = ispc_pkg::ST_CLEAR;
					cfg_nxt = config_flash[0];
				end
			end
			ispc_pkg::ST_CLEAR:
				state_nxt = ispc_pkg::ST_RUN; // logic held cleared [RULE17]
			ispc_pkg::ST_RUN:
				state_nxt = ispc_pkg::ST_USER; // logic runs before pins [RULE17]
			ispc_pkg::ST_USER:
				if (exec && op == `ISPC_OP_ENTER)
				begin
					state_nxt = ispc_pkg::ST_PROG; // [RULE1]
					pif.sample_stb = 1'b1; // [RULE2]
				end
				else if (exec && op == `ISPC_OP_RELOAD)
				begin
					state_nxt = ispc_pkg::ST_LOAD; // [RULE6]
					cnt_nxt = '0;
				end
				else if (exec && op == `ISPC_OP_BGMODE)
					bg_nxt = 1'b1; // [RULE4]
			ispc_pkg::ST_PROG:
				if (exec && (op == `ISPC_OP_EXIT || op == `ISPC_OP_RELOAD))
				begin
					state_nxt = ispc_pkg::ST_LOAD; // [RULE6]
					cnt_nxt = '0;
				end
			default:
				state_nxt = ispc_pkg::ST_OFF;
		endcase
		if (exec && op == `ISPC_OP_CLAMP && 32'(fa) < N)
		begin
			mode_nxt[32'(fa)*`ISPC_MODE_W +: `ISPC_MODE_W] = fd[`ISPC_MODE_W-1:0];
			clamp_nxt = 1'b1;
		end
		if (exec && wr_ok && op == `ISPC_OP_SET_SEC)
			sec_nxt = 1'b1;
		if (exec && wr_ok && op == `ISPC_OP_SET_DONE)
			done_nxt = 1'b1;
		if (erase)
		begin
			sec_nxt  = 1'b0; // only erase clears these [RULE9]
			done_nxt = 1'b0;
		end
		if (state_nxt == ispc_pkg::ST_LOAD)
		begin
			bg_nxt    = 1'b0;
			clamp_nxt = 1'b0;
		end
		if (!pwr_ok)
			state_nxt = ispc_pkg::ST_OFF;
		cut_nxt  = ~pwr_ok; // [RULE13]
		urst_nxt = state_nxt == ispc_pkg::ST_RUN || state_nxt == ispc_pkg::ST_USER
			|| state_nxt == ispc_pkg::ST_PROG;
	end

	// core drives pins only in user mode, powered, completed, not held; clamps drive in programming
	assign pif.gate_off = supply_low_cutoff | ~done_r | hold_r // [RULE12] [RULE13] [RULE16]
		| (state_r != ispc_pkg::ST_USER); // [RULE7] [RULE14] [RULE15]
	assign pif.prog     = state_r == ispc_pkg::ST_PROG && !supply_low_cutoff;
	assign pif.clamp_en = clamp_r;
	assign pif.mode     = mode_r;
	assign pif.user_out = user_out;
	assign pif.user_oe  = user_oe;
	assign pad_out      = pif.pad_out;
	assign pad_oe       = pif.pad_oe;
	assign pad_pu       = pif.pad_pu;

	ispc_pinbank #(.N(N)) i_ispc_pinbank (
		.clock (clock),
		.rstn  (rstn),
		.pif   (pif.bank)
	);

	// register port: writes steer hold and index, reads return state
	always_comb
	begin
		hold_nxt  = hold_r;
		uaddr_nxt = uaddr_r;
		rdata_nxt = '0;
		if (reg_wr && reg_addr == `ISPC_REG_CTRL)
			hold_nxt = reg_wdata[`ISPC_CTRL_HOLD];
		if (reg_wr && reg_addr == `ISPC_REG_UADDR)
			uaddr_nxt = reg_wdata[AW-1:0];
		if (reg_rd)
		begin
			case (reg_addr)
				`ISPC_REG_CTRL:  rdata_nxt = {31'h0, hold_r};
				`ISPC_REG_STAT:  rdata_nxt = {26'h0, supply_low_cutoff, bg_r, done_r, sec_r,
					state_r == ispc_pkg::ST_PROG, state_r == ispc_pkg::ST_USER};
				`ISPC_REG_UADDR: rdata_nxt = 32'(uaddr_r);
				`ISPC_REG_UDATA: rdata_nxt = {24'h0, user_flash[uaddr_r]}; // [RULE11]
				default:         rdata_nxt = '0;
			endcase
		end
	end

	// state registers
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			s1_r <= '0; s2_r <= '0; s3_r <= '0; filt_r <= '0;
			in_sh_r <= '0; bcnt_r <= '0; out_sh_r <= '0; tdo <= 1'b0;
			state_r <= ispc_pkg::ST_OFF; cnt_r <= '0; sec_r <= 1'b0; done_r <= 1'b0;
			bg_r <= 1'b0; clamp_r <= 1'b0; mode_r <= '0; logic_cfg <= '0;
			supply_low_cutoff <= 1'b1; user_rstn <= 1'b0;
			hold_r <= 1'b0; uaddr_r <= '0; reg_rdata <= '0;
		end
		else
		begin
			s1_r <= {io_supply_ok, core_supply_ok, tdi, tms, tck};
			s2_r <= s1_r; s3_r <= s2_r; filt_r <= filt_nxt;
			in_sh_r <= in_sh_nxt; bcnt_r <= bcnt_nxt; out_sh_r <= out_sh_nxt; tdo <= tdo_nxt;
			state_r <= state_nxt; cnt_r <= cnt_nxt; sec_r <= sec_nxt; done_r <= done_nxt;
			bg_r <= bg_nxt; clamp_r <= clamp_nxt; mode_r <= mode_nxt; logic_cfg <= cfg_nxt;
			supply_low_cutoff <= cut_nxt; user_rstn <= urst_nxt;
			hold_r <= hold_nxt; uaddr_r <= uaddr_nxt; reg_rdata <= rdata_nxt;
		end
	end

	// flash arrays; rstn stands for a blank part
	always_ff @(posedge clock)
	begin
		if (!rstn || erase)
		begin
			for (int k = 0; k < 2**AW; k++)
			begin
				config_flash[k] <= `ISPC_ERASED;
				if (!rstn)
					user_flash[k] <= `ISPC_ERASED;
			end
		end
		else
		begin
			if (cfg_we)
				config_flash[fa] <= fd;
			if (ufl_we)
				user_flash[fa] <= fd;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	cutoff_off_a: assert property (supply_low_cutoff |=> pad_oe == '0) // [RULE13]
		else $error("pins drive under supply cutoff");
	load_pullup_a: assert property (state_r == ispc_pkg::ST_LOAD |=> pad_pu == '1) // [RULE15]
		else $error("pull-ups off during load");
	load_hiz_a: assert property (state_r == ispc_pkg::ST_LOAD |=> pad_oe == '0) // [RULE14]
		else $error("pins drive during load");
	done_gate_a: assert property (!done_r && state_r != ispc_pkg::ST_PROG |=> pad_oe == '0) // [RULE16]
		else $error("pins drive before completion bit");
	secure_read_a: assert property (exec && wr_ok && op == `ISPC_OP_READ_CFG && sec_r // [RULE18]
		|=> out_sh_r == `ISPC_SECURE_PAT)
		else $error("secured readback leaked data");
	sec_erase_a: assert property ($fell(sec_r) |-> $past(erase)) // [RULE9]
		else $error("security bit cleared without erase");
	ufl_read_a: assert property (exec && wr_ok && op == `ISPC_OP_READ_UFL // [RULE11]
		|=> out_sh_r == $past(user_flash[fa]))
		else $error("user flash read blocked");
	bg_run_a: assert property (cfg_we && state_r == ispc_pkg::ST_USER && pwr_ok // [RULE4]
		|=> state_r == ispc_pkg::ST_USER && user_rstn)
		else $error("background write disturbed logic");
	reload_only_a: assert property (state_r == ispc_pkg::ST_LOAD // [RULE5]
		&& $past(state_r) == ispc_pkg::ST_USER |-> $past(exec && op == `ISPC_OP_RELOAD))
		else $error("load started without reload");
	reload_go_a: assert property (exec && op == `ISPC_OP_RELOAD && pwr_ok // [RULE6]
		&& state_r == ispc_pkg::ST_USER |=> state_r == ispc_pkg::ST_LOAD ##1 pad_oe == '0)
		else $error("reload did not start load");
	clear_order_a: assert property (pad_oe != '0 && state_r == ispc_pkg::ST_USER // [RULE17]
		|-> $past(user_rstn, 2))
		else $error("pins released before logic");
	prog_default_a: assert property (state_r == ispc_pkg::ST_PROG && !clamp_r // [RULE1]
		|=> pad_oe == '0 && pad_pu == '1)
		else $error("default programming pins not hi-z");

	enter_prog_c: cover property (exec && op == `ISPC_OP_ENTER ##1 state_r == ispc_pkg::ST_PROG);
	reload_c:     cover property (exec && op == `ISPC_OP_RELOAD);
	sec_read_c:   cover property (exec && op == `ISPC_OP_READ_CFG && sec_r);
	user_mode_c:  cover property (state_r == ispc_pkg::ST_USER && pad_oe != '0);
endmodule : ispc_top

// ===== ispc_host.sv
/*
 * link host model: shifts one 20-bit frame per call, msb first, and
 * captures eight answer bits from the first eight clocks of the frame.
 * assumes: the block samples the link with a much faster clock.
 */
`timescale 1ns/1ps
module ispc_host (
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo
);
	// link clock stands still low between frames
	initial
	begin
		tck = 1'b0;
		tms = 1'b0;
		tdi = 1'b0;
	end

	// one frame at a 125 ns link period; a reload frame is the host's part
	task automatic frame(input logic [3:0] op, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		logic [19:0] f;
		f = {op, a, d};
		q = 8'h00;
		tms = 1'b1;
		for (int i = 19; i >= 0; i--)
		begin
			tdi = f[i];
			#62.5 tck = 1'b1;
			#62.5 if (i > 11) q = {q[6:0], tdo};
			tck = 1'b0;
		end
		#62.5 tms = 1'b0;
		// released data line shows the inverse, never a stale level
		tdi = ~tdi;
		#100;
	endtask : frame
endmodule : ispc_host

// ===== test_isp_io_clamp_and_security.sv
/*
 * testbench: register port tasks, link frames through the host model,
 * pin and flash expectations worked out from the clamp and security rules.
 * assumes: load count shortened to 20 cycles.
 */
`timescale 1ns/1ps
`include "ispc_defs.svh"
module test_isp_io_clamp_and_security;
	logic        clock = 1'b0;  // 100 MHz clock
	logic        rstn  = 1'b0;  // reset, active low
	logic        tck, tms, tdi, tdo;
	logic        core_ok = 1'b0; // core supply good
	logic        io_ok   = 1'b0; // io supply good
	logic [7:0]  user_out = 8'h08;
	logic [7:0]  user_oe  = 8'h0B;
	logic [7:0]  pad_out, pad_oe, pad_pu, logic_cfg, reg_addr = 8'h00;
	logic        user_rstn, supply_low_cutoff, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, q;
	logic [7:0]  b;             // link answer byte
	int          mismatches = 0, n_tests = 0, cyc = 0;
	logic [2:0]  md [5] = '{`ISPC_MODE_HIGH, `ISPC_MODE_LOW, `ISPC_MODE_HIZ,
		`ISPC_MODE_SAMPLE, `ISPC_MODE_SAMPLE};

	always #5 clock = ~clock;

	ispc_top #(.LOAD_CYC(20)) i_ispc_top (.clock(clock), .rstn(rstn), .tck(tck), .tms(tms),
		.tdi(tdi), .tdo(tdo), .core_supply_ok(core_ok), .io_supply_ok(io_ok),
		.user_out(user_out), .user_oe(user_oe), .pad_out(pad_out), .pad_oe(pad_oe),
		.pad_pu(pad_pu), .user_rstn(user_rstn), .logic_cfg(logic_cfg),
		.supply_low_cutoff(supply_low_cutoff), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	ispc_host i_ispc_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

	// verdict and end of run
	task close_out;
		if (mismatches == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out

	// hang guard
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			mismatches++;
			close_out;
		end
	end

	// one comparison
	task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			mismatches++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask : cmp

	// register write, one strobe cycle
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr

	// register read, data in the next cycle only
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd

	// frame, answer kept in b
	task fr(input logic [3:0] op, input logic [7:0] a, input logic [7:0] d);
		i_ispc_host.frame(op, a, d, b);
	endtask : fr

	// poll status until user mode
	task wait_user;
		q = 32'h0;
		for (int k = 0; k < 100 && q[0] !== 1'b1; k++)
			rd(`ISPC_REG_STAT, q);
		cmp("user mode", 32'h1, {31'h0, q[0]});
	endtask : wait_user

	// pads off with pull-ups
	task pads_off(input string nm);
		cmp(nm, 32'h0, pad_oe);
		cmp(nm, 32'hFF, pad_pu);
	endtask : pads_off

	initial
	begin
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		core_ok <= 1'b1;
		io_ok <= 1'b1;
		#1 pads_off("reset pads");
		cmp("reset cutoff", 32'h1, supply_low_cutoff);
		repeat (12) @(posedge clock);
		#1 pads_off("load pads");
		wait_user;
		cmp("core reset", 32'h1, user_rstn);
		cmp("blank part oe", 32'h0, pad_oe);
		for (int i = 0; i < 5; i++)
			fr(`ISPC_OP_CLAMP, i, {5'h0, md[i]});
		fr(`ISPC_OP_ENTER, 0, 0);
		cmp("clamp oe", 32'h0B, pad_oe);
		cmp("clamp out", 32'h09, pad_out & pad_oe);
		cmp("clamp pu", 32'hE0, pad_pu & 8'hE4);
		fr(`ISPC_OP_PROG_CFG, 0, 8'h5A);
		fr(`ISPC_OP_PROG_UFL, 3, 8'h3C);
		fr(`ISPC_OP_SET_DONE, 0, 0);
		fr(`ISPC_OP_READ_CFG, 0, 0);
		fr(4'h0, 0, 0);
		cmp("cfg read", 32'h5A, b);
		fr(`ISPC_OP_EXIT, 0, 0);
		pads_off("exit load");
		wait_user;
		cmp("cfg loaded", 32'h5A, logic_cfg);
		cmp("user oe", 32'h0B, pad_oe);
		cmp("user out", 32'h08, pad_out & pad_oe);
		wr(`ISPC_REG_CTRL, 32'h1);
		repeat (2) @(posedge clock);
		#1 cmp("hold oe", 32'h0, pad_oe);
		wr(`ISPC_REG_CTRL, 32'h0);
		rd(8'h10, q);
		cmp("unmapped", 32'h0, q);
		fr(`ISPC_OP_BGMODE, 0, 0);
		fr(`ISPC_OP_PROG_CFG, 0, 8'hA5);
		cmp("bg oe", 32'h0B, pad_oe);
		cmp("bg cfg", 32'h5A, logic_cfg);
		fr(`ISPC_OP_RELOAD, 0, 0);
		pads_off("reload pads");
		wait_user;
		cmp("reload cfg", 32'hA5, logic_cfg);
		fr(`ISPC_OP_BGMODE, 0, 0);
		fr(`ISPC_OP_SET_SEC, 0, 0);
		fr(`ISPC_OP_READ_CFG, 0, 0);
		fr(`ISPC_OP_READ_UFL, 3, 0);
		cmp("secure read", `ISPC_SECURE_PAT, b);
		fr(4'h0, 0, 0);
		cmp("user flash link", 32'h3C, b);
		wr(`ISPC_REG_UADDR, 32'h3);
		rd(`ISPC_REG_UDATA, q);
		cmp("user flash port", 32'h3C, q);
		fr(`ISPC_OP_RELOAD, 0, 0);
		wait_user;
		rd(`ISPC_REG_STAT, q);
		cmp("sec kept", 32'h1, q[2]);
		fr(`ISPC_OP_BGMODE, 0, 0);
		fr(`ISPC_OP_ERASE, 0, 0);
		rd(`ISPC_REG_STAT, q);
		cmp("sec erased", 32'h0, q[2]);
		// programming with no clamp armed keeps the default pin state
		fr(`ISPC_OP_ENTER, 0, 0);
		pads_off("default prog");
		fr(`ISPC_OP_READ_CFG, 0, 0);
		fr(4'h0, 0, 0);
		cmp("erased read", `ISPC_ERASED, b);
		@(posedge clock);
		core_ok <= 1'b0;
		repeat (10) @(posedge clock);
		#1 cmp("cutoff", 32'h1, supply_low_cutoff);
		cmp("cutoff oe", 32'h0, pad_oe);
		// supply return is a power cycle: the erased image loads
		@(posedge clock);
		core_ok <= 1'b1;
		wait_user;
		cmp("power cycle cfg", `ISPC_ERASED, logic_cfg);
		@(posedge clock);
		io_ok <= 1'b0;
		repeat (10) @(posedge clock);
		#1 cmp("io cutoff", 32'h1, supply_low_cutoff);
		cmp("io cutoff oe", 32'h0, pad_oe);
		close_out;
	end
endmodule : test_isp_io_clamp_and_security
